// ### rtl/sdc_decode.sv
// Command decoder, mode register and data path of a synchronous DRAM.
// Assumes the pins arrive unsynchronised and the array answers reads
// combinationally in the cycle of the request.
module sdc_decode
    import sdc_pkg::*;
#(
    parameter int BUF_DEPTH = 2
)
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic cke_in,
    input wire logic cs_n_in,
    input wire logic ras_n_in,
    input wire logic cas_n_in,
    input wire logic we_n_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [BANK_W-1:0] ba_in,
    input wire logic [MASK_W-1:0] dqm_in,
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic [MASK_W-1:0] dq_oe_out,
    output sdc_cmd_info_t cmd_out,
    output sdc_mode_t mode_out,
    output logic mode_normal_out,
    output logic refresh_out,
    output logic [ADDR_W-1:0] refresh_row_out,
    output logic self_refresh_out,
    output sdc_rd_req_t rd_req_out,
    input wire logic [DATA_W-1:0] rd_data_in,
    output sdc_wr_beat_t wr_beat_out,
    output logic wr_valid_out,
    input wire logic wr_ready_in,
    output logic wr_full_out
);

    localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int CNT_W = $clog2(BUF_DEPTH + 1);
    localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(BUF_DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(BUF_DEPTH - 1);
    localparam logic [BEAT_W-1:0] BEAT_ONE = 9'h001;

    function automatic sdc_cmd_t decode_cmd(input sdc_pins_t p);
        sdc_cmd_t c;
        c = CMD_MODE_LOAD;
        if (p.cs_n)
        begin
            c = CMD_INHIBIT;
        end
        else if ({p.ras_n, p.cas_n, p.we_n} == ENC_NOP)
        begin
            c = CMD_NOP;
        end
        else if ({p.ras_n, p.cas_n, p.we_n} == ENC_ACTIVE)
        begin
            c = CMD_ACTIVE;
        end
        else if ({p.ras_n, p.cas_n, p.we_n} == ENC_READ)
        begin
            c = CMD_READ;
        end
        else if ({p.ras_n, p.cas_n, p.we_n} == ENC_WRITE)
        begin
            c = CMD_WRITE;
        end
        else if ({p.ras_n, p.cas_n, p.we_n} == ENC_BST)
        begin
            c = CMD_BST;
        end
        else if ({p.ras_n, p.cas_n, p.we_n} == ENC_PRECHARGE)
        begin
            c = CMD_PRECHARGE;
        end
        else if ({p.ras_n, p.cas_n, p.we_n} == ENC_REFRESH)
        begin
            c = CMD_REFRESH;
        end
        return c;
    endfunction : decode_cmd

    function automatic logic [BEAT_W-1:0] bl_beats(input logic [2:0] bl);
        case (bl)
            BL_1: return BEATS_1;
            BL_2: return BEATS_2;
            BL_4: return BEATS_4;
            BL_8: return BEATS_8;
            BL_PAGE: return BEATS_PAGE;
            default: return BEATS_1;
        endcase
    endfunction : bl_beats

    // Column of a beat, wrapping inside the burst block
    function automatic logic [COL_W-1:0] beat_col(
        input logic [COL_W-1:0] start,
        input logic [COL_W-1:0] idx,
        input logic [2:0] bl,
        input logic bt
    );
        logic [COL_W-1:0] m;
        logic [COL_W-1:0] off;
        case (bl)
            BL_2: m = BLK_MASK_2;
            BL_4: m = BLK_MASK_4;
            BL_8: m = BLK_MASK_8;
            BL_PAGE: m = BLK_MASK_PAGE;
            default: m = BLK_MASK_1;
        endcase
        // Interleave has no page form, so pages always count up
        off = (bt && bl != BL_PAGE) ? (start ^ idx) : (start + idx);
        return (start & ~m) | (off & m);
    endfunction : beat_col

    // Reserved latency codes fall back to the slowest setting
    function automatic logic [1:0] cl_cycles(input logic [2:0] f);
        case (f)
            CL_1: return 2'h1;
            CL_2: return 2'h2;
            default: return 2'h3;
        endcase
    endfunction : cl_cycles

    // Pin synchroniser
    sdc_pins_t pin_raw;
    sdc_pins_t pin_s1_q;
    sdc_pins_t pin_q;
    assign pin_raw = {cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in,
                      addr_in, ba_in, dqm_in, dq_in};

    always_ff @(posedge core_clk_in)
    begin
        pin_s1_q <= pin_raw;
        pin_q <= pin_s1_q;
    end

    // Command, mode register and refresh
    sdc_cmd_t cmd;
    sdc_cmd_info_t cmd_d, cmd_q;
    sdc_mode_t mode_d, mode_q;
    logic ref_d, ref_q;
    logic self_d, self_q;
    logic [ADDR_W-1:0] ref_row_d, ref_row_q;

    always_comb
    begin
        // Only clock enable is watched while self refreshing
        cmd = self_q ? CMD_INHIBIT : decode_cmd(pin_q);
        mode_d = mode_q;
        ref_d = 1'b0;
        ref_row_d = ref_row_q;
        self_d = self_q;
        cmd_d.valid = (cmd != CMD_INHIBIT) && (cmd != CMD_NOP);
        cmd_d.cmd = cmd;
        cmd_d.bank = pin_q.ba;
        cmd_d.row = pin_q.addr;
        cmd_d.auto_pre = pin_q.addr[AP_BIT] &&
            (cmd == CMD_READ || cmd == CMD_WRITE);
        cmd_d.pre_all = pin_q.addr[AP_BIT] && cmd == CMD_PRECHARGE;
        if (cmd == CMD_MODE_LOAD)
        begin
            mode_d = sdc_mode_t'(pin_q.addr);
        end
        if (cmd == CMD_REFRESH)
        begin
            cmd_d.bank = '0;
            cmd_d.row = ref_row_q;
            if (pin_q.cke)
            begin
                ref_d = 1'b1;
                ref_row_d = ref_row_q + 1'b1;
            end
            else
            begin
                self_d = 1'b1;
            end
        end
        else if (self_q && pin_q.cke)
        begin
            self_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            cmd_q <= '0;
            mode_q <= sdc_mode_t'(MODE_RESET);
            ref_q <= 1'b0;
            self_q <= 1'b0;
            ref_row_q <= '0;
        end
        else
        begin
            cmd_q <= cmd_d;
            mode_q <= mode_d;
            ref_q <= ref_d;
            self_q <= self_d;
            ref_row_q <= ref_row_d;
        end
    end

    // Burst sequencer
    sdc_burst_st_t st_d, st_q;
    logic [BANK_W-1:0] bank_d, bank_q;
    logic [COL_W-1:0] start_d, start_q;
    logic [BEAT_W-1:0] idx_d, idx_q;
    logic [BEAT_W-1:0] beats_d, beats_q;
    logic [2:0] bl_d, bl_q;
    logic bt_d, bt_q;
    logic endless_d, endless_q;
    logic rd_now;
    logic wr_now;
    logic [COL_W-1:0] now_col;
    logic [BANK_W-1:0] now_bank;

    always_comb
    begin
        st_d = st_q;
        bank_d = bank_q;
        start_d = start_q;
        idx_d = idx_q;
        beats_d = beats_q;
        bl_d = bl_q;
        bt_d = bt_q;
        endless_d = endless_q;
        rd_now = 1'b0;
        wr_now = 1'b0;
        now_col = beat_col(start_q, idx_q[COL_W-1:0], bl_q, bt_q);
        now_bank = bank_q;
        if (cmd == CMD_READ || cmd == CMD_WRITE)
        begin
            bank_d = pin_q.ba;
            start_d = pin_q.addr[COL_W-1:0];
            bl_d = mode_q.burst_length_field;
            bt_d = mode_q.burst_type;
            beats_d = bl_beats(mode_q.burst_length_field);
            if (cmd == CMD_WRITE && mode_q.write_burst_single_bit)
            begin
                beats_d = BEATS_1;
                bl_d = BL_1;
            end
            endless_d = beats_d == BEATS_PAGE;
            idx_d = BEAT_ONE;
            now_col = pin_q.addr[COL_W-1:0];
            now_bank = pin_q.ba;
            rd_now = cmd == CMD_READ;
            wr_now = cmd == CMD_WRITE;
            st_d = (beats_d == BEATS_1) ? ST_IDLE :
                   (cmd == CMD_READ) ? ST_RD : ST_WR;
        end
        else if (cmd == CMD_BST || cmd == CMD_PRECHARGE)
        begin
            // Precharge also cuts a running burst short
            st_d = ST_IDLE;
        end
        else
        begin
            case (st_q)
                ST_RD,
                ST_WR:
                begin
                    // Deselect and no-op leave the burst running
                    rd_now = st_q == ST_RD;
                    wr_now = st_q == ST_WR;
                    idx_d = idx_q + BEAT_ONE;
                    if (!endless_q && idx_d == beats_q)
                    begin
                        st_d = ST_IDLE;
                    end
                end
                default:
                begin
                    st_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            st_q <= ST_IDLE;
            bank_q <= '0;
            start_q <= '0;
            idx_q <= '0;
            beats_q <= '0;
            bl_q <= BL_1;
            bt_q <= 1'b0;
            endless_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            bank_q <= bank_d;
            start_q <= start_d;
            idx_q <= idx_d;
            beats_q <= beats_d;
            bl_q <= bl_d;
            bt_q <= bt_d;
            endless_q <= endless_d;
        end
    end

    // Read data path with programmable latency
    sdc_rd_req_t rd_req_d, rd_req_q;
    logic [CL_MAX-1:0] rd_pipe_d, rd_pipe_q;
    logic [DATA_W-1:0] dpipe_d [CL_MAX-1];
    logic [DATA_W-1:0] dpipe_q [CL_MAX-1];
    logic [MASK_W-1:0] dqm_p1_q, dqm_p2_q;
    logic [DATA_W-1:0] dq_d, dq_q;
    logic [MASK_W-1:0] oe_d, oe_q;
    logic [1:0] lat;
    logic drive_now;
    logic data_now;

    always_comb
    begin
        lat = cl_cycles(mode_q.read_latency_field);
        rd_req_d = {rd_now, now_bank, now_col};
        rd_pipe_d = {rd_pipe_q[CL_MAX-2:0], rd_now};
        dpipe_d[0] = rd_data_in;
        dpipe_d[1] = dpipe_q[0];
        dq_d = dq_q;
        case (lat)
            2'h1:
            begin
                drive_now = rd_now;
                data_now = rd_pipe_q[0];
                if (data_now)
                begin
                    dq_d = rd_data_in;
                end
            end
            2'h2:
            begin
                drive_now = rd_pipe_q[0];
                data_now = rd_pipe_q[1];
                if (data_now)
                begin
                    dq_d = dpipe_q[0];
                end
            end
            default:
            begin
                drive_now = rd_pipe_q[1];
                data_now = rd_pipe_q[2];
                if (data_now)
                begin
                    dq_d = dpipe_q[1];
                end
            end
        endcase
        // Mask registered two edges back floats its byte
        oe_d = {MASK_W{drive_now || data_now}} & ~dqm_p2_q;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            rd_req_q <= '0;
            rd_pipe_q <= '0;
            dpipe_q[0] <= '0;
            dpipe_q[1] <= '0;
            dqm_p1_q <= '0;
            dqm_p2_q <= '0;
            dq_q <= '0;
            oe_q <= '0;
        end
        else
        begin
            rd_req_q <= rd_req_d;
            rd_pipe_q <= rd_pipe_d;
            dpipe_q[0] <= dpipe_d[0];
            dpipe_q[1] <= dpipe_d[1];
            dqm_p1_q <= pin_q.dqm;
            dqm_p2_q <= dqm_p1_q;
            dq_q <= dq_d;
            oe_q <= oe_d;
        end
    end

    // Write beat buffer; a beat arriving while full is lost and shows
    // only as the full flag, since the pins cannot be stalled
    sdc_wr_beat_t wmem_d [BUF_DEPTH];
    sdc_wr_beat_t wmem_q [BUF_DEPTH];
    logic [PTR_W-1:0] wptr_d, wptr_q, rptr_d, rptr_q;
    logic [CNT_W-1:0] cnt_d, cnt_q;
    sdc_wr_beat_t head_d, head_q;
    logic push;
    logic pop;

    always_comb
    begin
        wmem_d = wmem_q;
        push = wr_now && cnt_q != DEPTH_C;
        pop = cnt_q != '0 && wr_ready_in;
        wptr_d = wptr_q;
        rptr_d = rptr_q;
        cnt_d = cnt_q;
        if (push)
        begin
            // Mask travels with its own beat
            wmem_d[wptr_q] = {now_bank, now_col, pin_q.dq, pin_q.dqm};
            wptr_d = (wptr_q == PTR_LAST) ? '0 : wptr_q + 1'b1;
        end
        if (pop)
        begin
            rptr_d = (rptr_q == PTR_LAST) ? '0 : rptr_q + 1'b1;
        end
        cnt_d = cnt_q + CNT_W'(push) - CNT_W'(pop);
        head_d = wmem_d[rptr_d];
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            wmem_q <= '{default: '0};
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q <= '0;
            head_q <= '0;
        end
        else
        begin
            wmem_q <= wmem_d;
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            cnt_q <= cnt_d;
            head_q <= head_d;
        end
    end

    // Outputs straight from flops
    logic normal_q;
    logic wr_valid_q;
    logic wr_full_q;

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            normal_q <= 1'b0;
            wr_valid_q <= 1'b0;
            wr_full_q <= 1'b0;
        end
        else
        begin
            normal_q <= {mode_d.op_mode_bit_high,
                         mode_d.op_mode_bit_low} == OPM_NORMAL;
            wr_valid_q <= cnt_d != '0;
            wr_full_q <= cnt_d == DEPTH_C;
        end
    end

    assign dq_out = dq_q;
    assign dq_oe_out = oe_q;
    assign cmd_out = cmd_q;
    assign mode_out = mode_q;
    assign mode_normal_out = normal_q;
    assign refresh_out = ref_q;
    assign refresh_row_out = ref_row_q;
    assign self_refresh_out = self_q;
    assign rd_req_out = rd_req_q;
    assign wr_beat_out = head_q;
    assign wr_valid_out = wr_valid_q;
    assign wr_full_out = wr_full_q;

endmodule : sdc_decode

// ### rtl/sdc_pkg.sv
// Shared types, encodings and mode-register layout of the command decoder.
// Assumes one clock domain; the users import the whole package.
package sdc_pkg;

    localparam int ADDR_W = 12;
    localparam int BANK_W = 2;
    localparam int DATA_W = 32;
    localparam int MASK_W = 4;
    localparam int COL_W = 8;
    localparam int BEAT_W = 9;
    localparam int CL_MAX = 3;
    localparam int AP_BIT = 10;

    // Strobe encodings {row, column, write enable}, all active low
    localparam logic [2:0] ENC_NOP = 3'h7;
    localparam logic [2:0] ENC_ACTIVE = 3'h3;
    localparam logic [2:0] ENC_READ = 3'h5;
    localparam logic [2:0] ENC_WRITE = 3'h4;
    localparam logic [2:0] ENC_BST = 3'h6;
    localparam logic [2:0] ENC_PRECHARGE = 3'h2;
    localparam logic [2:0] ENC_REFRESH = 3'h1;

    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [COL_W-1:0] BLK_MASK_1 = 8'h00;
    localparam logic [COL_W-1:0] BLK_MASK_2 = 8'h01;
    localparam logic [COL_W-1:0] BLK_MASK_4 = 8'h03;
    localparam logic [COL_W-1:0] BLK_MASK_8 = 8'h07;
    localparam logic [COL_W-1:0] BLK_MASK_PAGE = 8'hFF;
    localparam logic [BEAT_W-1:0] BEATS_1 = 9'h001;
    localparam logic [BEAT_W-1:0] BEATS_2 = 9'h002;
    localparam logic [BEAT_W-1:0] BEATS_4 = 9'h004;
    localparam logic [BEAT_W-1:0] BEATS_8 = 9'h008;
    localparam logic [BEAT_W-1:0] BEATS_PAGE = 9'h100;
    localparam logic [1:0] OPM_NORMAL = 2'h0;
    localparam logic [2:0] CL_1 = 3'h1;
    localparam logic [2:0] CL_2 = 3'h2;
    localparam logic [2:0] CL_3 = 3'h3;
    // Defined start-up contents: burst of one, latency two, normal mode
    localparam logic [ADDR_W-1:0] MODE_RESET = 12'h020;

    typedef enum logic [3:0] {
        CMD_INHIBIT = 4'h0,
        CMD_NOP = 4'h1,
        CMD_ACTIVE = 4'h2,
        CMD_READ = 4'h3,
        CMD_WRITE = 4'h4,
        CMD_BST = 4'h5,
        CMD_PRECHARGE = 4'h6,
        CMD_REFRESH = 4'h7,
        CMD_MODE_LOAD = 4'h8
    } sdc_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_RD = 2'h1,
        ST_WR = 2'h3
    } sdc_burst_st_t;

    typedef struct packed {
        logic [1:0] reserved;
        logic write_burst_single_bit;
        logic op_mode_bit_high;
        logic op_mode_bit_low;
        logic [2:0] read_latency_field;
        logic burst_type;
        logic [2:0] burst_length_field;
    } sdc_mode_t;

    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
        logic [BANK_W-1:0] ba;
        logic [MASK_W-1:0] dqm;
        logic [DATA_W-1:0] dq;
    } sdc_pins_t;

    typedef struct packed {
        logic valid;
        sdc_cmd_t cmd;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] row;
        logic auto_pre;
        logic pre_all;
    } sdc_cmd_info_t;

    typedef struct packed {
        logic valid;
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0] col;
    } sdc_rd_req_t;

    typedef struct packed {
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0] col;
        logic [DATA_W-1:0] data;
        logic [MASK_W-1:0] mask;
    } sdc_wr_beat_t;

endpackage : sdc_pkg

// ### verif/sdc_decode_sva.sv
// Timing checks on the pins and outputs of the command decoder.
// Assumes pins are held deselected while reset is high.
module sdc_decode_sva
    import sdc_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic cke_in,
    input wire logic cs_n_in,
    input wire logic ras_n_in,
    input wire logic cas_n_in,
    input wire logic we_n_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [BANK_W-1:0] ba_in,
    input wire logic [MASK_W-1:0] dqm_in,
    input wire logic [MASK_W-1:0] dq_oe_out,
    input wire sdc_cmd_info_t cmd_out,
    input wire sdc_mode_t mode_out,
    input wire logic mode_normal_out,
    input wire logic refresh_out,
    input wire logic [ADDR_W-1:0] refresh_row_out,
    input wire logic self_refresh_out,
    input wire logic wr_valid_out,
    input wire logic wr_full_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ap_pin;
    assign ap_pin = addr_in[AP_BIT];
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    // Two sync flops plus decode register: three edges pin to record
    sequence s_pin(logic [2:0] enc);
        !cs_n_in && {ras_n_in, cas_n_in, we_n_in} == enc;
    endsequence
    sequence s_cl2_read;
        s_pin(ENC_READ) ##0 mode_out.read_latency_field == CL_2;
    endsequence
    chk_inhibit_no_cmd: assert property (cs_n_in |-> ##3 !cmd_out.valid)
        else $error("deselect produced a command");
    chk_nop_no_cmd: assert property (s_pin(ENC_NOP) |-> ##3 !cmd_out.valid)
        else $error("no-op produced a command");
    chk_active_row: assert property (s_pin(ENC_ACTIVE) |-> ##3
        cmd_out.cmd == CMD_ACTIVE && cmd_out.row == $past(addr_in, 3)
        && cmd_out.bank == $past(ba_in, 3))
        else $error("activate decoded wrongly");
    chk_read_autopre: assert property (s_pin(ENC_READ) |-> ##3
        cmd_out.cmd == CMD_READ && cmd_out.auto_pre == $past(ap_pin, 3))
        else $error("read decoded wrongly");
    chk_prech_all: assert property (s_pin(ENC_PRECHARGE) |-> ##3
        cmd_out.cmd == CMD_PRECHARGE && cmd_out.pre_all == $past(ap_pin, 3))
        else $error("precharge scope wrong");
    chk_mode_store: assert property (s_pin(3'h0) ##0 cke_in |-> ##3
        mode_out == $past(addr_in, 3))
        else $error("mode register not loaded");
    chk_normal_flag: assert property (!$past(rst_in) |->
        mode_normal_out == !(mode_out.op_mode_bit_high
        || mode_out.op_mode_bit_low))
        else $error("normal flag disagrees with mode");
    chk_auto_refresh: assert property (s_pin(ENC_REFRESH) ##0 cke_in
        |-> ##3 refresh_out ##1 !refresh_out)
        else $error("auto refresh pulse wrong");
    chk_self_entry: assert property (s_pin(ENC_REFRESH) ##0 !cke_in
        |-> ##3 self_refresh_out && !refresh_out)
        else $error("self refresh not entered");
    chk_refresh_row: assert property (cmd_out.valid
        && cmd_out.cmd == CMD_REFRESH
        |-> refresh_row_out == cmd_out.row + {11'h000, refresh_out})
        else $error("refresh row not from counter");
    chk_read_drive: assert property (s_cl2_read |-> ##3 dq_oe_out == 4'h0
        ##1 dq_oe_out == ~$past(dqm_in, 5))
        else $error("read drive edge or mask wrong");
    chk_full_valid: assert property (wr_full_out |-> wr_valid_out)
        else $error("full buffer shows no data");
endmodule : sdc_decode_sva

bind sdc_decode sdc_decode_sva chk_i (.core_clk_in, .rst_in, .cke_in,
    .cs_n_in, .ras_n_in, .cas_n_in, .we_n_in, .addr_in, .ba_in, .dqm_in,
    .dq_oe_out, .cmd_out, .mode_out, .mode_normal_out, .refresh_out,
    .refresh_row_out, .self_refresh_out, .wr_valid_out, .wr_full_out);

// ### verif/sdc_ctrl_model.sv
// Memory controller model: drives the command pins one cycle a command.
// Assumes the caller keeps clock enable high outside self refresh.
module sdc_ctrl_model
    import sdc_pkg::*;
#(
    parameter int MRD_GAP = 2
)
(
    input wire logic clk_in,
    output sdc_pins_t pins_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial pins_out = {5'h1F, 50'h0};
    // Command for one edge, then a selected no-op; cke and dqm persist
    task automatic send(logic s, logic [2:0] enc, logic [11:0] a,
        logic [1:0] b, logic k, logic [3:0] m, logic [31:0] d);
        @(posedge clk_in);
        pins_out <= {k, s, enc, a, b, m, d};
        @(posedge clk_in);
        {pins_out.cs_n, pins_out.ras_n, pins_out.cas_n, pins_out.we_n} <= 4'h7;
    endtask : send
    // Bank lines low, then no-ops over the load delay
    task automatic load_mode(logic [11:0] op);
        send(1'b0, 3'h0, op, 2'h0, 1'b1, pins_out.dqm, 32'h0);
        repeat (MRD_GAP) @(posedge clk_in);
    endtask : load_mode
endmodule : sdc_ctrl_model

// ### verif/sdc_decode_test.sv
// Self-checking bench of the command decoder with a controller model.
// Assumes the array answers reads in the cycle of the request.
module sdc_decode_test
    import sdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic wr_ready = 1'b0;
    sdc_pins_t pins;
    logic [31:0] dq_out, dq_wire, rd_data;
    logic [3:0] dq_oe_out;
    sdc_cmd_info_t cmd_out;
    sdc_mode_t mode_out;
    logic mode_normal_out, refresh_out, self_refresh_out;
    logic wr_valid_out, wr_full_out;
    logic [11:0] refresh_row_out;
    sdc_rd_req_t rd_req_out;
    sdc_wr_beat_t wr_beat_out;
    int fails = 0;
    int cmp_count = 0;
    always #2.5 core_clk_in = ~core_clk_in;
    assign rd_data = {4{rd_req_out.col}};
    // Shared data wire: a driving byte of the decoder overrides the model
    always_comb
        for (int b = 0; b < 4; b++)
            dq_wire[8*b +: 8] = dq_oe_out[b] ? dq_out[8*b +: 8]
                : pins.dq[8*b +: 8];
    sdc_ctrl_model ctrl (.clk_in(core_clk_in), .pins_out(pins));
    sdc_decode uut (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .cke_in(pins.cke), .cs_n_in(pins.cs_n), .ras_n_in(pins.ras_n),
        .cas_n_in(pins.cas_n), .we_n_in(pins.we_n), .addr_in(pins.addr),
        .ba_in(pins.ba), .dqm_in(pins.dqm), .dq_in(dq_wire),
        .dq_out(dq_out), .dq_oe_out(dq_oe_out), .cmd_out(cmd_out),
        .mode_out(mode_out), .mode_normal_out(mode_normal_out),
        .refresh_out(refresh_out), .refresh_row_out(refresh_row_out),
        .self_refresh_out(self_refresh_out), .rd_req_out(rd_req_out),
        .rd_data_in(rd_data), .wr_beat_out(wr_beat_out),
        .wr_valid_out(wr_valid_out), .wr_ready_in(wr_ready),
        .wr_full_out(wr_full_out));
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done
    // Pin command reaches cmd_out two edges after the model lets go
    task automatic after_cmd;
        repeat (2) @(posedge core_clk_in);
        #1;
    endtask : after_cmd
    task automatic t_mode;
        chk("reset mode", MODE_RESET, mode_out);
        ctrl.load_mode(12'h180);
        after_cmd;
        chk("normal", 0, mode_normal_out);
        ctrl.load_mode(12'h232);
        after_cmd;
        chk("mode", 12'h232, mode_out);
        chk("latency field", CL_3, mode_out.read_latency_field);
        chk("single bit", 1, mode_out.write_burst_single_bit);
        chk("normal", 1, mode_normal_out);
    endtask : t_mode
    task automatic t_decode;
        ctrl.send(1'b1, ENC_READ, 12'h400, 2'h1, 1'b1, 4'h0, 32'h0);
        after_cmd;
        chk("inhibit", 0, cmd_out.valid);
        ctrl.send(1'b0, ENC_NOP, 12'h400, 2'h1, 1'b1, 4'h0, 32'h0);
        after_cmd;
        chk("nop", 0, cmd_out.valid);
        ctrl.send(1'b0, ENC_ACTIVE, 12'hABC, 2'h2, 1'b1, 4'h0, 32'h0);
        after_cmd;
        chk("active", {CMD_ACTIVE, 2'h2, 12'hABC},
            {cmd_out.cmd, cmd_out.bank, cmd_out.row});
        ctrl.send(1'b0, ENC_PRECHARGE, 12'h000, 2'h3, 1'b1, 4'h0, 32'h0);
        after_cmd;
        chk("pre one", {CMD_PRECHARGE, 2'h3, 1'b0},
            {cmd_out.cmd, cmd_out.bank, cmd_out.pre_all});
        ctrl.send(1'b0, ENC_PRECHARGE, 12'h400, 2'h0, 1'b1, 4'h0, 32'h0);
        after_cmd;
        chk("pre all", 1, cmd_out.pre_all);
        ctrl.send(1'b0, ENC_BST, 12'h000, 2'h0, 1'b1, 4'h0, 32'h0);
        after_cmd;
        chk("terminate", {1'b1, CMD_BST}, {cmd_out.valid, cmd_out.cmd});
    endtask : t_decode
    task automatic t_read;
        int i;
        logic [2:0] m;
        ctrl.send(1'b0, ENC_NOP, 12'h000, 2'h0, 1'b1, 4'h5, 32'h0);
        for (m = 3'h1; m <= 3'h3; m++)
        begin
            ctrl.load_mode({5'h00, m, 4'h0});
            after_cmd;
            ctrl.send(1'b0, ENC_READ, 12'h4A7, 2'h1, 1'b1, 4'h5, 32'h0);
            i = 0;
            while (dq_oe_out === 4'h0 && i < 9)
            begin
                @(posedge core_clk_in);
                #1;
                i++;
            end
            chk("drive edge", m + 1, i);
            chk("byte drive", 4'hA, dq_oe_out);
            @(posedge core_clk_in);
            #1;
            chk("read data", 32'hA700A700, dq_out & 32'hFF00FF00);
            repeat (4) @(posedge core_clk_in);
        end
    endtask : t_read
    task automatic t_refresh;
        ctrl.send(1'b0, ENC_REFRESH, 12'hFFF, 2'h3, 1'b1, 4'h0, 32'h0);
        after_cmd;
        chk("refresh", 1, refresh_out);
        chk("row", {12'h000, 12'h001}, {cmd_out.row, refresh_row_out});
        ctrl.send(1'b0, ENC_REFRESH, 12'h000, 2'h0, 1'b0, 4'h0, 32'h0);
        after_cmd;
        chk("self", 2'h2, {self_refresh_out, refresh_out});
        ctrl.send(1'b1, ENC_NOP, 12'h000, 2'h0, 1'b1, 4'h0, 32'h0);
        repeat (5) @(posedge core_clk_in);
        #1;
        chk("self exit", 0, self_refresh_out);
    endtask : t_refresh
    task automatic pops(output int n, output sdc_wr_beat_t first);
        n = 0;
        first = '0;
        #1;
        repeat (12)
        begin
            if (wr_valid_out === 1'b1 && wr_ready === 1'b1)
            begin
                if (n == 0)
                    first = wr_beat_out;
                n++;
            end
            @(posedge core_clk_in);
            #1;
        end
    endtask : pops
    task automatic t_write;
        int n;
        sdc_wr_beat_t bt;
        logic [11:0] op [3] = '{12'h021, 12'h221, 12'h022};
        @(posedge core_clk_in);
        wr_ready <= 1'b1;
        for (int j = 0; j < 3; j++)
        begin
            ctrl.load_mode(op[j]);
            if (j == 2)
                wr_ready <= 1'b0;
            ctrl.send(1'b0, ENC_WRITE, 12'h010, 2'h2, 1'b1, 4'h3, 32'h12345678);
            if (j == 2)
            begin
                // Stalled array: two beats kept, the rest refused
                repeat (8) @(posedge core_clk_in);
                #1;
                chk("full", 2'h3, {wr_full_out, wr_valid_out});
                @(posedge core_clk_in);
                wr_ready <= 1'b1;
            end
            pops(n, bt);
            chk("beats", j == 1 ? 1 : 2, n);
            chk("beat data", 32'h12345678, bt.data);
            chk("beat addr", {2'h2, 8'h10, 4'h3},
                {bt.bank, bt.col, bt.mask});
        end
        chk("drained", 0, wr_valid_out);
    endtask : t_write
    initial
    begin
        repeat (5000) @(posedge core_clk_in);
        fails++;
        test_done;
    end
    initial
    begin
        repeat (10) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(posedge core_clk_in);
        #1;
        t_mode;
        t_decode;
        t_read;
        t_refresh;
        t_write;
        test_done;
    end
endmodule : sdc_decode_test
